/* shared/wds_consts.vh */
// Constants for the watchdog and sleep controller.
// Assumes inclusion by bare name from the design files.
`ifndef WDS_CONSTS_VH
`define WDS_CONSTS_VH

// Register offsets within a bank
`define WDS_OFF_OPTION   7'h01
`define WDS_OFF_STATUS   7'h03
`define WDS_OFF_CTRL     7'h04
// Common RAM window, last 16 bytes
`define WDS_RAM_BASE     7'h70
`define WDS_RAM_DEPTH    16

// Option register layout and reset value
`define WDS_OPTION_RST   8'hFF
`define WDS_PSA_BIT      3
`define WDS_PS_HI        2
`define WDS_PS_LO        0

// Status register flag positions
`define WDS_TO_BIT       4
`define WDS_PD_BIT       3

// Control register layout
`define WDS_CTRL_XTAL_BIT 0

// Timing
`define WDS_CLK_HZ       20000000
`define WDS_BASE_MS      18
// Base period in core_clk cycles, 18 ms at 20 MHz
`define WDS_BASE_CYC     19'h57E40

// Interrupt vector
`define WDS_IRQ_VECTOR   13'h0004

`endif

/* hw/wds_top.v */
// Watchdog timer, prescaler and sleep controller with status flags.
// Assumes instruction strobes, interrupt flags and fuses synchronous to core_clk.
//
// Notes on behaviour
// RULE_01: Watchdog counts from a free-running source, unaffected by sleep.
// RULE_02: Watchdog expiry while running requests a full device reset.
// RULE_03: Watchdog expiry while asleep wakes and resumes execution.
// RULE_04: Watchdog stays disabled whenever its enable fuse is zero.
// RULE_05: Unscaled timeout is nominally 18 ms.
// RULE_06: Option register assigns a prescaler up to 1:128 to the watchdog.
// RULE_07: Clear and sleep instructions reset counter and assigned prescaler.
// RULE_08: Every timeout clears the active-low timeout flag.
// RULE_09: Sleep entry clears watchdog, clears power-down, sets timeout, stops oscillator.
// RULE_10: I/O pins hold their pre-sleep drive state during sleep.
// RULE_11: Watchdog reset is internal only, never drives master clear pin.
// RULE_12: Master clear wakes via reset; watchdog and interrupt wakes resume.
// RULE_13: Power-down flag set at power-up; timeout flag cleared on watchdog wake.
// RULE_14: Only clockless interrupt sources may wake the device.
// RULE_15: Interrupt wakes only with its own enable set, regardless of global enable.
// RULE_16: Wake runs prefetched instruction, then vectors to 0004h if global enable.
// RULE_17: Global enable clear with enabled pending flag wakes immediately.
// RULE_18: Watchdog counter resets on every wake-up.
// RULE_19: In crystal modes watchdog is held cleared until start-up timer ends.
// RULE_20: Interrupt entry pushes only the return program counter.
// RULE_21: Last 16 RAM bytes are shared by every bank.
// RULE_22: Firmware places a no-operation after sleep if needed.
// RULE_23: Prescaler assigned elsewhere gives the unscaled base timeout.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "wds_consts.vh"

module wds_top #(
  parameter [18:0] BASE_CYC = `WDS_BASE_CYC
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire [8:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_q,
  input  wire        watchdog_enable_fuse,
  input  wire        watchdog_clear_instr,
  input  wire        sleep_instr,
  input  wire        master_clear_pin_n,
  input  wire        osc_startup_timer_done,
  input  wire        global_irq_enable,
  input  wire [5:0]  wake_irq_flags,
  input  wire [5:0]  wake_irq_enables,
  input  wire        irq_entry,
  input  wire [12:0] return_pc,
  output reg         dev_reset_q,
  output reg         wdt_timeout_q,
  output reg         osc_drv_en_q,
  output reg         io_hold_q,
  output reg         resume_q,
  output reg         vector_q,
  output reg  [12:0] vector_addr_q,
  output reg         stack_push_q,
  output reg  [12:0] stack_pc_q,
  output reg         timeout_flag_n_q,
  output reg         powerdown_flag_n_q,
  output reg         sleeping_q
);

  // ==========================================================
  // States
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_OSTW  = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [18:0] base_cnt_q;
  reg  [18:0] base_cnt_d;
  reg  [6:0]  pre_cnt_q;
  reg  [6:0]  pre_cnt_d;
  reg  [7:0]  option_q;
  reg         xtal_mode_q;
  reg         irq_wake_q;
  reg         vec_pend_q;
  reg         master_clear_pin_q;
  reg         timeout_flag_n_d;
  reg         powerdown_flag_n_d;
  reg  [7:0]  reg_rdata_d;
  reg  [7:0]  common_ram [0:`WDS_RAM_DEPTH-1];

  // ==========================================================
  // Decode and conditions
  wire [6:0] reg_off    = reg_addr[6:0];
  wire       ram_hit    = ({reg_off[6:4], 4'h0} == `WDS_RAM_BASE); // RULE_21
  wire [3:0] ram_idx    = reg_off[3:0];
  wire       prescaler_assign        = option_q[`WDS_PSA_BIT];
  wire [2:0] ps_sel     = option_q[`WDS_PS_HI:`WDS_PS_LO];
  // Last prescaler count: 2^ps - 1 when assigned, zero otherwise
  wire [6:0] pre_last   = prescaler_assign ? ~(7'h7F << ps_sel) : 7'h00; // RULE_06 RULE_23
  wire       base_last  = (base_cnt_q == BASE_CYC - 19'h00001); // RULE_05
  wire       master_clear_pin       = ~master_clear_pin_n;
  // Clockless sources only, each gated by its own enable
  wire       irq_pend   = |(wake_irq_flags & wake_irq_enables); // RULE_14 RULE_15
  wire       in_run     = (state_q == ST_RUN);
  wire       in_sleep   = (state_q == ST_SLEEP);
  wire       in_ostw    = (state_q == ST_OSTW);
  // Pending interrupt turns sleep into a no-operation
  wire       sleep_exec = in_run & sleep_instr & ~irq_pend & ~master_clear_pin; // RULE_17
  wire       wake_irq   = in_sleep & irq_pend & ~master_clear_pin; // RULE_17
  wire       wdt_clr;
  wire       wdt_expire;

  assign wdt_clr = ~watchdog_enable_fuse // RULE_04
                 | (in_run & watchdog_clear_instr) // RULE_07
                 | sleep_exec // RULE_07 RULE_09
                 | wake_irq // RULE_18
                 | in_ostw // RULE_19
                 | master_clear_pin;

  // Any clear in the expiry cycle wins
  assign wdt_expire = watchdog_enable_fuse & base_last & (pre_cnt_q == pre_last)
                    & ~wdt_clr;

  // ==========================================================
  // Watchdog counter and prescaler
  // Counter is never gated by sleep state
  always @* begin
    base_cnt_d = base_cnt_q + 19'h00001; // RULE_01
    pre_cnt_d  = pre_cnt_q;
    if (wdt_clr || wdt_expire) begin
      base_cnt_d = 19'h00000; // RULE_07 RULE_18
      pre_cnt_d  = 7'h00;
    end else if (base_last) begin
      base_cnt_d = 19'h00000; // RULE_01
      pre_cnt_d  = pre_cnt_q + 7'h01; // RULE_06
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      base_cnt_q <= 19'h00000;
      pre_cnt_q  <= 7'h00;
    end else begin
      base_cnt_q <= base_cnt_d;
      pre_cnt_q  <= pre_cnt_d;
    end
  end

  // ==========================================================
  // Sleep state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_exec) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (master_clear_pin) begin
          state_d = ST_RUN; // RULE_12
        end else if (wdt_expire || wake_irq) begin
          state_d = xtal_mode_q ? ST_OSTW : ST_RUN; // RULE_03 RULE_19
        end
      end
      ST_OSTW: begin
        if (master_clear_pin || osc_startup_timer_done) begin
          state_d = ST_RUN; // RULE_19
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Status flag next values
  // Master clear acts on its first low cycle only, so a long
  // pulse that starts in sleep still leaves power-down clear
  always @* begin
    timeout_flag_n_d   = timeout_flag_n_q;
    powerdown_flag_n_d = powerdown_flag_n_q;
    if (master_clear_pin) begin
      if (!master_clear_pin_q) begin
        timeout_flag_n_d = 1'b1;
        if (!in_sleep) begin
          powerdown_flag_n_d = 1'b1;
        end
      end
    end else if (wdt_expire) begin
      // Sleep entry clears the watchdog, so no expiry in the same cycle
      timeout_flag_n_d = 1'b0; // RULE_08 RULE_13
    end else if (sleep_exec) begin
      timeout_flag_n_d   = 1'b1; // RULE_09
      powerdown_flag_n_d = 1'b0; // RULE_09 RULE_13
    end
  end

  // ==========================================================
  // Master clear history and status flags
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_q             <= 1'b0;
      timeout_flag_n_q   <= 1'b1;
      powerdown_flag_n_q <= 1'b1; // RULE_13
    end else begin
      master_clear_pin_q             <= master_clear_pin;
      timeout_flag_n_q   <= timeout_flag_n_d;
      powerdown_flag_n_q <= powerdown_flag_n_d;
    end
  end

  // ==========================================================
  // Reset request and timeout pulse
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dev_reset_q   <= 1'b0;
      wdt_timeout_q <= 1'b0;
    end else begin
      wdt_timeout_q <= wdt_expire;
      // Internal reset only; master clear pin is never driven
      dev_reset_q   <= master_clear_pin | (wdt_expire & in_run); // RULE_02 RULE_11
    end
  end

  // ==========================================================
  // Wake sequencing
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_wake_q    <= 1'b0;
      resume_q      <= 1'b0;
      vec_pend_q    <= 1'b0;
      vector_q      <= 1'b0;
      vector_addr_q <= 13'h0000;
    end else begin
      resume_q <= 1'b0;
      vector_q <= 1'b0;
      if (master_clear_pin) begin
        irq_wake_q <= 1'b0;
        vec_pend_q <= 1'b0;
      end else begin
        if (sleep_exec) begin
          irq_wake_q <= 1'b0;
        end
        if (wake_irq) begin
          irq_wake_q <= 1'b1;
        end
        // Leaving sleep: run the prefetched instruction first
        if (state_d == ST_RUN && !in_run) begin
          resume_q   <= 1'b1; // RULE_03 RULE_12 RULE_16
          vec_pend_q <= (irq_wake_q | wake_irq) & global_irq_enable;
        end else if (vec_pend_q) begin
          vec_pend_q    <= 1'b0;
          vector_q      <= 1'b1; // RULE_16
          vector_addr_q <= `WDS_IRQ_VECTOR;
        end
      end
    end
  end

  // ==========================================================
  // Oscillator driver, pin hold and sleep indication
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_drv_en_q <= 1'b1;
      io_hold_q    <= 1'b0;
      sleeping_q   <= 1'b0;
    end else begin
      osc_drv_en_q <= (state_d != ST_SLEEP); // RULE_09
      io_hold_q    <= (state_d != ST_RUN); // RULE_10
      sleeping_q   <= (state_d == ST_SLEEP);
    end
  end

  // ==========================================================
  // Interrupt entry: only the return address is pushed
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stack_push_q <= 1'b0;
      stack_pc_q   <= 13'h0000;
    end else begin
      stack_push_q <= irq_entry; // RULE_20
      if (irq_entry) begin
        stack_pc_q <= return_pc; // RULE_20
      end
    end
  end

  // ==========================================================
  // Register port
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      option_q    <= `WDS_OPTION_RST;
      xtal_mode_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_off == `WDS_OFF_OPTION) begin
        option_q <= reg_wdata; // RULE_06
      end
      if (reg_off == `WDS_OFF_CTRL) begin
        xtal_mode_q <= reg_wdata[`WDS_CTRL_XTAL_BIT];
      end
    end
  end

  // Shared RAM ignores the bank bits
  always @(posedge core_clk) begin
    if (reg_wr && ram_hit) begin
      common_ram[ram_idx] <= reg_wdata; // RULE_21
    end
  end

  always @* begin
    reg_rdata_d = 8'h00;
    if (reg_rd) begin
      if (ram_hit) begin
        reg_rdata_d = common_ram[ram_idx]; // RULE_21
      end else begin
        case (reg_off)
          `WDS_OFF_OPTION: reg_rdata_d = option_q;
          `WDS_OFF_STATUS: begin
            reg_rdata_d = {3'h0, timeout_flag_n_q, powerdown_flag_n_q, 3'h0};
          end
          `WDS_OFF_CTRL:   reg_rdata_d = {7'h00, xtal_mode_q};
          default:         reg_rdata_d = 8'h00;
        endcase
      end
    end
  end

  // Read data stands for one cycle only
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

endmodule

/* dv/wds_asserts.sv */
// Concurrent checks on the watchdog and sleep controller ports.
// Assumes a single core_clk domain and binding onto wds_top.
`timescale 1ns/10ps
module wds_asserts (
  input wire        core_clk,
  input wire        nrst,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata_q,
  input wire        watchdog_enable_fuse,
  input wire        master_clear_pin_n,
  input wire        irq_entry,
  input wire [12:0] return_pc,
  input wire        dev_reset_q,
  input wire        wdt_timeout_q,
  input wire        osc_drv_en_q,
  input wire        io_hold_q,
  input wire        resume_q,
  input wire        vector_q,
  input wire [12:0] vector_addr_q,
  input wire        stack_push_q,
  input wire [12:0] stack_pc_q,
  input wire        timeout_flag_n_q,
  input wire        powerdown_flag_n_q,
  input wire        sleeping_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Sequences
  sequence s_push;
    ##1 (stack_push_q && stack_pc_q == $past(return_pc));
  endsequence
  sequence s_vec;
    $past(resume_q) ##1 (vector_addr_q == 13'h0004);
  endsequence
  // ==========================================================
  // Properties
  chk_fuse_off: assert property (!watchdog_enable_fuse && !$past(watchdog_enable_fuse)
    |-> !wdt_timeout_q) else $error("timeout with fuse off");
  chk_to_clear: assert property (wdt_timeout_q && master_clear_pin_n
    |-> !timeout_flag_n_q) else $error("timeout flag not cleared");
  chk_sleep_pins: assert property (sleeping_q |-> !osc_drv_en_q && io_hold_q)
    else $error("oscillator or pins wrong in sleep");
  chk_sleep_flags: assert property ($rose(sleeping_q)
    |-> !powerdown_flag_n_q && (timeout_flag_n_q || wdt_timeout_q))
    else $error("flags wrong on sleep entry");
  chk_vec_order: assert property (vector_q |-> s_vec)
    else $error("vector without resume");
  chk_stack_push: assert property (irq_entry |-> s_push)
    else $error("stack push wrong");
  chk_sleep_wake: assert property (wdt_timeout_q && $past(sleeping_q) && master_clear_pin_n
    && $past(master_clear_pin_n) |-> !dev_reset_q) else $error("reset on sleep wake");
  chk_run_reset: assert property (wdt_timeout_q && !$past(sleeping_q) && !$past(io_hold_q)
    |-> dev_reset_q) else $error("no reset on run timeout");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data outside read slot");
endmodule

bind wds_top wds_asserts i_wds_asserts (.core_clk, .nrst, .reg_rd, .reg_rdata_q,
  .watchdog_enable_fuse, .master_clear_pin_n, .irq_entry, .return_pc, .dev_reset_q,
  .wdt_timeout_q, .osc_drv_en_q, .io_hold_q, .resume_q, .vector_q, .vector_addr_q,
  .stack_push_q, .stack_pc_q, .timeout_flag_n_q, .powerdown_flag_n_q, .sleeping_q);

/* dv/tb_top.sv */
// Self-checking bench for the watchdog and sleep controller.
// Assumes wds_top with a short base period and the checker bound on.
`timescale 1ns/10ps
module tb_top;
  localparam int BC = 16;
  logic        core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, irq_entry = 0;
  logic        watchdog_enable_fuse = 1, watchdog_clear_instr = 0, sleep_instr = 0;
  logic        master_clear_pin_n = 1, osc_startup_timer_done = 1, global_irq_enable = 0;
  logic [8:0]  reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata_q, d;
  logic [5:0]  wake_irq_flags = 0, wake_irq_enables = 0;
  logic [12:0] return_pc = 0, vector_addr_q, stack_pc_q, pc;
  logic        dev_reset_q, wdt_timeout_q, osc_drv_en_q, io_hold_q, resume_q, vector_q;
  logic        stack_push_q, timeout_flag_n_q, powerdown_flag_n_q, sleeping_q;
  int          error_cnt = 0, n_tests = 0, n, k, e, to_seen;

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (wdt_timeout_q === 1'b1) to_seen++;

  wds_top #(.BASE_CYC(19'(BC))) i_wds_top (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .watchdog_enable_fuse, .watchdog_clear_instr, .sleep_instr,
    .master_clear_pin_n, .osc_startup_timer_done, .global_irq_enable, .wake_irq_flags,
    .wake_irq_enables, .irq_entry, .return_pc, .dev_reset_q, .wdt_timeout_q, .osc_drv_en_q,
    .io_hold_q, .resume_q, .vector_q, .vector_addr_q, .stack_push_q, .stack_pc_q,
    .timeout_flag_n_q, .powerdown_flag_n_q, .sleeping_q);

  // ==========================================================
  // Tasks
  task check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  function automatic int exp_period(input logic [7:0] o);
    return o[3] ? BC << o[2:0] : BC;
  endfunction
  task wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge core_clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
    @(posedge core_clk); reg_wr <= 0;
  endtask
  task rd(input logic [8:0] a, input logic [7:0] ex);
    @(posedge core_clk); reg_addr <= a; reg_rd <= 1;
    @(posedge core_clk); reg_rd <= 0;
    #1 check("rdata", reg_rdata_q, ex);
  endtask
  task instr(input bit s);
    @(posedge core_clk); if (s) sleep_instr <= 1; else watchdog_clear_instr <= 1;
    @(posedge core_clk); sleep_instr <= 0; watchdog_clear_instr <= 0;
  endtask
  task wait_hi(input bit sel, input int lim, output int cyc);
    for (cyc = 1; cyc <= lim; cyc++) begin
      @(posedge core_clk); #1;
      if ((sel ? resume_q : wdt_timeout_q) === 1'b1) return;
    end
    error_cnt++;
    $display("unexpected wait %0d: expected pulse seen none", sel);
    final_report;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    d = $urandom(32'h04B7);
    tick(6); nrst <= 1;
    rd(9'h003, 8'h18); rd(9'h001, 8'hFF); rd(9'h005, 8'h00);
    for (k = 0; k < 4; k++) begin
      d = $urandom; n = $urandom_range(15, 0);
      wr(9'(9'h070 + n), d); rd(9'(9'h170 + n), d);
    end
    $display("test registers done");
    for (k = 0; k < 5; k++) begin
      d = {4'h0, k != 0, 3'($urandom_range(3, 0))};
      e = exp_period(d);
      wr(9'h001, d); instr(0); wait_hi(0, 300, n);
      check("period", n >= e - 1 && n <= e + 2, 1);
      check("run_reset", dev_reset_q, 1);
      rd(9'h003, 8'h08);
    end
    wr(9'h001, 8'h00); instr(0); to_seen = 0;
    repeat (6) begin instr(0); tick(8); end
    check("cleared", to_seen, 0);
    instr(0); watchdog_enable_fuse <= 0; to_seen = 0; tick(100);
    check("fuse_off", to_seen, 0);
    watchdog_enable_fuse <= 1;
    $display("test periods done");
    wr(9'h001, 8'h00); instr(1); #1 check("asleep", sleeping_q, 1);
    rd(9'h003, 8'h10); wait_hi(0, 40, n);
    check("sleep_reset", dev_reset_q, 0);
    tick(3); #1 check("awake", sleeping_q, 0);
    rd(9'h003, 8'h00);
    wr(9'h001, 8'h0F);
    for (k = 0; k < 6; k++) begin
      global_irq_enable <= k[0]; wake_irq_enables <= 6'h01 << k;
      if (k == 5) begin wr(9'h004, 8'h01); osc_startup_timer_done <= 0; end
      instr(1); wake_irq_flags <= 6'h01 << ((k + 1) % 6); tick(4);
      #1 check("masked", sleeping_q, 1);
      tick(1); wake_irq_flags <= wake_irq_flags | (6'h01 << k);
      if (k == 5) begin
        tick(5); #1 check("ost_hold", {io_hold_q, osc_drv_en_q, resume_q}, 3'b110);
        osc_startup_timer_done <= 1;
      end
      wait_hi(1, 20, n); @(posedge core_clk);
      #1 check("vector", vector_q, k[0]);
      check("vec_addr", vector_addr_q, k == 0 ? 13'h0000 : 13'h0004);
      wake_irq_flags <= 0;
    end
    wr(9'h004, 8'h00);
    $display("test wake sources done");
    instr(1); tick(2); master_clear_pin_n <= 0; tick(2);
    #1 check("master_clear_pin_reset", dev_reset_q, 1);
    @(posedge core_clk); master_clear_pin_n <= 1; tick(2);
    rd(9'h003, 8'h10);
    @(posedge core_clk); pc = 13'($urandom); return_pc <= pc; irq_entry <= 1;
    @(posedge core_clk); irq_entry <= 0;
    #1 check("stack_pc", stack_pc_q, pc);
    check("stack_push", stack_push_q, 1);
    $display("test reset sources done");
    final_report;
  end
endmodule
